// ===== nrm_core.sv
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module nrm_core #(
    parameter int AW = 8
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [15:0] IO_ADDR,
    output logic [15:0] IO_DATA_O,
    output logic IO_DATA_OE,
    output logic IO_STROBE_N,
    output logic IO_DSTRB_N,
    output logic IO_WRITE_N,
    input wire logic IO_READY
);
    logic [1:0] rs_ff;
    logic rst_n;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rs_ff <= 2'b00;
        end else begin
            rs_ff <= {rs_ff[0], 1'b1};
        end
    end
    assign rst_n = rs_ff[1];
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
        return o;
    endfunction : wmerge
    function automatic logic [15:0] ar_mod(input logic [15:0] a, input logic [2:0] m,
                                           input logic [15:0] a0);
        case (m)
            nrm_pkg::MOD_DEC: ar_mod = a - 16'h0001;
            nrm_pkg::MOD_INC: ar_mod = a + 16'h0001;
            nrm_pkg::MOD_SUB0: ar_mod = a - a0;
            nrm_pkg::MOD_ADD0: ar_mod = a + a0;
            default: ar_mod = a;
        endcase
    endfunction : ar_mod
    function automatic logic [31:0] pshift(input logic [31:0] p, input logic [1:0] m);
        case (m)
            nrm_pkg::PM_LSH1: pshift = {p[30:0], 1'b0};
            nrm_pkg::PM_LSH4: pshift = {p[27:0], 4'h0};
            nrm_pkg::PM_RSH6: pshift = {{6{p[31]}}, p[31:6]};
            default: pshift = p;
        endcase
    endfunction : pshift
    nrm_pkg::nrm_state_e st_ff;
    logic [15:0] ctrl_ff;
    logic [31:0] acc_ff;
    logic [31:0] preg_ff;
    logic [15:0] ar_ff [0:7];
    logic tflag_ff;
    logic [15:0] pc_ff;
    logic [15:0] op_ff;
    logic [15:0] k_ff;
    logic [7:0] rpt_ff;
    logic [AW-1:0] maddr_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic [15:0] io_addr_ff;
    logic [15:0] io_data_ff;
    logic io_act_ff;
    logic [15:0] mem_q;
    logic wr_fire, rd_fire, busy, ex, nz_zero, nz_shift, ar_step;
    logic is_idle, is_normalize_step, is_ork, is_pac, is_or, is_out;
    logic [2:0] aux_pointer;
    logic [1:0] pm;
    logic [31:0] ork_sh;
    logic [AW-1:0] mem_ra;
    logic [7:0] wa;
    assign wr_fire = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_ff;
    assign rd_fire = S_AXI_ARVALID && !rvalid_ff;
    assign S_AXI_AWREADY = wr_fire;
    assign S_AXI_WREADY = wr_fire;
    assign S_AXI_ARREADY = rd_fire;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RRESP = rresp_ff;
    assign S_AXI_RDATA = rdata_ff;
    assign wa = S_AXI_AWADDR;
    assign busy = (st_ff != nrm_pkg::ST_IDLE);
    assign aux_pointer = ctrl_ff[nrm_pkg::CTRL_ARP_LO +: 3];
    assign pm = ctrl_ff[nrm_pkg::CTRL_PM_LO +: 2];
    // Decode of the latched opcode
    assign is_idle = (op_ff[15:7] == nrm_pkg::OP_IDLE[15:7]);
    assign is_normalize_step = ((op_ff & nrm_pkg::MSK_NORMALIZE_STEP) == nrm_pkg::OP_NORMALIZE_STEP);
    assign is_ork = ((op_ff & nrm_pkg::MSK_ORK) == nrm_pkg::OP_ORK);
    assign is_pac = (op_ff == nrm_pkg::OP_PAC);
    assign is_or = (op_ff[15:8] == nrm_pkg::OP_OR_HI);
    assign is_out = (op_ff[15:12] == nrm_pkg::OP_OUT_HI);
    assign ex = (st_ff == nrm_pkg::ST_EXEC);
    assign nz_zero = ctrl_ff[nrm_pkg::CTRL_NEWER] && (acc_ff == 32'h0000_0000);
    assign nz_shift = !nz_zero && (acc_ff[31] == acc_ff[30]);
    assign ar_step = ex && ((is_normalize_step && nz_shift) || ((is_or || is_out) && op_ff[7]));
    assign ork_sh = {16'h0000, k_ff} << op_ff[11:8];
    // Direct field is seven bits; indirect takes the low address bits of the pointer
    assign mem_ra = op_ff[7] ? ar_ff[aux_pointer][AW-1:0] : AW'(op_ff[6:0]);
    nrm_dmem #(.AW(AW), .DW(16)) i_nrm_dmem (
        .clk(CLK),
        .we(wr_fire && wa == nrm_pkg::REG_MDATA),
        .waddr(maddr_ff),
        .wdata(S_AXI_WDATA[15:0]),
        .raddr(mem_ra),
        .rdata(mem_q)
    );
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= nrm_pkg::ST_IDLE;
            op_ff <= nrm_pkg::OP_IDLE;
            k_ff <= 16'h0000;
            rpt_ff <= 8'h00;
        end else begin
            case (st_ff)
                nrm_pkg::ST_IDLE: begin
                    // Issue ignored while an instruction is under way
                    if (wr_fire && wa == nrm_pkg::REG_INSTR) begin
                        op_ff <= S_AXI_WDATA[15:0];
                        k_ff <= S_AXI_WDATA[31:16];
                        rpt_ff <= ctrl_ff[nrm_pkg::CTRL_RPT_LO +: 8];
                        st_ff <= nrm_pkg::ST_FETCH;
                    end
                end
                nrm_pkg::ST_FETCH: st_ff <= nrm_pkg::ST_EXEC;
                nrm_pkg::ST_EXEC: begin
                    if (is_out) begin
                        st_ff <= nrm_pkg::ST_IO;
                    end else if (is_normalize_step && rpt_ff != 8'h00) begin
                        rpt_ff <= rpt_ff - 8'h01;
                    end else begin
                        st_ff <= nrm_pkg::ST_IDLE;
                    end
                end
                nrm_pkg::ST_IO: begin
                    if (IO_READY) begin
                        st_ff <= nrm_pkg::ST_IDLE;
                    end
                end
                default: st_ff <= nrm_pkg::ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= 32'h0000_0000;
        end else if (ex) begin
            if (is_normalize_step && nz_shift) begin
                acc_ff <= {acc_ff[30:0], 1'b0};
            end else if (is_ork) begin
                acc_ff <= {acc_ff[31], acc_ff[30:0] | ork_sh[30:0]};
            end else if (is_or) begin
                acc_ff[15:0] <= acc_ff[15:0] | mem_q;
            end else if (is_pac) begin
                acc_ff <= pshift(preg_ff, pm);
            end
        end else if (!busy && wr_fire && wa == nrm_pkg::REG_ACC) begin
            acc_ff <= wmerge(acc_ff, S_AXI_WDATA, S_AXI_WSTRB);
        end
    end
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tflag_ff <= 1'b0;
        end else if (ex && is_normalize_step) begin
            tflag_ff <= !nz_shift;
        end
    end
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                ar_ff[i] <= 16'h0000;
            end
        end else if (ar_step) begin
            ar_ff[aux_pointer] <= ar_mod(ar_ff[aux_pointer], op_ff[6:4], ar_ff[0]);
        end else if (!busy && wr_fire && wa[7:5] == nrm_pkg::REG_AR0[7:5]) begin
            ar_ff[wa[4:2]] <= 16'(wmerge({16'h0000, ar_ff[wa[4:2]]}, S_AXI_WDATA, S_AXI_WSTRB));
        end
    end
    // Two-word immediate form advances by two
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pc_ff <= 16'h0000;
        end else if (ex && !is_out && !(is_normalize_step && rpt_ff != 8'h00)) begin
            pc_ff <= pc_ff + (is_ork ? 16'h0002 : 16'h0001);
        end else if (st_ff == nrm_pkg::ST_IO && IO_READY) begin
            pc_ff <= pc_ff + 16'h0001;
        end
    end
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= nrm_pkg::CTRL_RST;
            preg_ff <= 32'h0000_0000;
            maddr_ff <= '0;
        end else if (wr_fire && !busy) begin
            if (wa == nrm_pkg::REG_CTRL) begin
                ctrl_ff <= 16'(wmerge({16'h0000, ctrl_ff}, S_AXI_WDATA, S_AXI_WSTRB));
            end
            if (wa == nrm_pkg::REG_PROD) begin
                preg_ff <= wmerge(preg_ff, S_AXI_WDATA, S_AXI_WSTRB);
            end
            if (wa == nrm_pkg::REG_MADDR) begin
                maddr_ff <= S_AXI_WDATA[AW-1:0];
            end
        end
    end
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            io_act_ff <= 1'b0;
            io_addr_ff <= 16'h0000;
            io_data_ff <= 16'h0000;
        end else if (ex && is_out) begin
            io_act_ff <= 1'b1;
            io_addr_ff <= {12'h000, op_ff[11:8]};
            io_data_ff <= mem_q;
        end else if (st_ff == nrm_pkg::ST_IO && IO_READY) begin
            io_act_ff <= 1'b0;
        end
    end
    assign IO_ADDR = io_addr_ff;
    assign IO_DATA_O = io_data_ff;
    assign IO_DATA_OE = io_act_ff;
    assign IO_STROBE_N = !io_act_ff;
    assign IO_DSTRB_N = !io_act_ff;
    assign IO_WRITE_N = !io_act_ff;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= nrm_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wa[7:6] == 2'b00 && wa[1:0] == 2'b00) ?
                        nrm_pkg::RESP_OKAY : nrm_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= nrm_pkg::RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= nrm_pkg::RESP_OKAY;
            case (S_AXI_ARADDR)
                nrm_pkg::REG_CTRL: rdata_ff <= {16'h0000, ctrl_ff};
                nrm_pkg::REG_STATUS: rdata_ff <= {29'h0, io_act_ff, busy, tflag_ff};
                nrm_pkg::REG_ACC: rdata_ff <= acc_ff;
                nrm_pkg::REG_PROD: rdata_ff <= preg_ff;
                nrm_pkg::REG_INSTR: rdata_ff <= {k_ff, op_ff};
                nrm_pkg::REG_IPTR: rdata_ff <= {16'h0000, pc_ff};
                nrm_pkg::REG_MADDR: rdata_ff <= 32'(maddr_ff);
                nrm_pkg::REG_MDATA: rdata_ff <= 32'h0000_0000;
                default: begin
                    if (S_AXI_ARADDR[7:5] == nrm_pkg::REG_AR0[7:5] &&
                        S_AXI_ARADDR[1:0] == 2'b00) begin
                        rdata_ff <= {16'h0000, ar_ff[S_AXI_ARADDR[4:2]]};
                    end else begin
                        rdata_ff <= 32'h0000_0000;
                        rresp_ff <= nrm_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end else if (S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end
    property p_idle;
        ex && is_idle |=> acc_ff == $past(acc_ff) && pc_ff == $past(pc_ff) + 16'h0001;
    endproperty
    a_idle: assert property (p_idle) else $error("idle op changed state");
    property p_normalize_step_zero;
        ex && is_normalize_step && ctrl_ff[0] && acc_ff == 32'h0 |=> tflag_ff && acc_ff == 32'h0;
    endproperty
    a_normalize_step_zero: assert property (p_normalize_step_zero) else $error("zero normalize wrong");
    property p_normalize_step_shift;
        ex && is_normalize_step && acc_ff != 32'h0 && acc_ff[31] == acc_ff[30]
            |=> !tflag_ff && acc_ff == {$past(acc_ff[30:0]), 1'b0};
    endproperty
    a_normalize_step_shift: assert property (p_normalize_step_shift) else $error("normalize shift wrong");
    property p_normalize_step_ar;
        ex && is_normalize_step && nz_shift && op_ff[6:4] == nrm_pkg::MOD_INC
            |=> ar_ff[aux_pointer] == $past(ar_ff[aux_pointer]) + 16'h0001;
    endproperty
    a_normalize_step_ar: assert property (p_normalize_step_ar) else $error("aux step missing");
    property p_normalize_step_stop;
        ex && is_normalize_step && acc_ff[31] != acc_ff[30] |=> $stable(acc_ff) && tflag_ff;
    endproperty
    a_normalize_step_stop: assert property (p_normalize_step_stop) else $error("normalize kept shifting");
    property p_normalize_step_old;
        ex && is_normalize_step && !ctrl_ff[0] && acc_ff == 32'h0 |=> !tflag_ff;
    endproperty
    a_normalize_step_old: assert property (p_normalize_step_old) else $error("old variant zero test");
    property p_ork;
        ex && is_ork |=> acc_ff[31] == $past(acc_ff[31]) &&
            acc_ff[30:0] == ($past(acc_ff[30:0]) | $past(ork_sh[30:0]));
    endproperty
    a_ork: assert property (p_ork) else $error("immediate OR wrong");
    property p_out_pins;
        !IO_STROBE_N |-> IO_ADDR == {12'h000, op_ff[11:8]} && IO_DATA_OE && !IO_WRITE_N;
    endproperty
    a_out_pins: assert property (p_out_pins) else $error("port address wrong");
    property p_out_data;
        ex && is_out |=> !IO_STROBE_N && IO_DATA_O == $past(mem_q);
    endproperty
    a_out_data: assert property (p_out_data) else $error("port data wrong");
    property p_out_hold;
        !IO_STROBE_N && !IO_READY |=> !IO_STROBE_N;
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("strobe dropped early");
    property p_pac;
        ex && is_pac && pm == nrm_pkg::PM_RSH6 |=> acc_ff == {{6{preg_ff[31]}}, preg_ff[31:6]};
    endproperty
    a_pac: assert property (p_pac) else $error("product shift wrong");
    property p_or_mem;
        ex && is_or |=> acc_ff[31:16] == $past(acc_ff[31:16]) &&
            acc_ff[15:0] == ($past(acc_ff[15:0]) | $past(mem_q));
    endproperty
    a_or_mem: assert property (p_or_mem) else $error("memory OR wrong");
    c_normalize_step_rpt: cover property (ex && is_normalize_step && rpt_ff != 8'h00 && !nz_shift);
    c_out: cover property (!IO_STROBE_N ##1 IO_STROBE_N);
    c_ork: cover property (ex && is_ork && op_ff[11:8] == 4'hF);
endmodule : nrm_core

// ===== nrm_io_model.sv
`timescale 1ns/1ps
module nrm_io_model (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [15:0] IO_ADDR,
    input wire logic [15:0] IO_DATA_O,
    input wire logic IO_DATA_OE,
    input wire logic IO_STROBE_N,
    input wire logic IO_DSTRB_N,
    input wire logic IO_WRITE_N,
    input wire logic [3:0] delay,
    output logic IO_READY,
    output logic [15:0] got_addr,
    output logic [15:0] got_data,
    output logic [7:0] nwr
);
    logic [3:0] cnt_ff;
    // Latch only while strobe low; floating bus seen as inverted data
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_ff <= 4'h0;
            IO_READY <= 1'b0;
            got_addr <= 16'h0000;
            got_data <= 16'h0000;
            nwr <= 8'h00;
        end else begin
            IO_READY <= 1'b0;
            if (!IO_STROBE_N && !IO_DSTRB_N && !IO_WRITE_N && !IO_READY) begin
                if (cnt_ff == delay) begin
                    IO_READY <= 1'b1;
                    cnt_ff <= 4'h0;
                    got_addr <= IO_ADDR;
                    got_data <= IO_DATA_OE ? IO_DATA_O : ~IO_DATA_O;
                    nwr <= nwr + 8'h01;
                end else begin
                    cnt_ff <= cnt_ff + 4'h1;
                end
            end
        end
    end
endmodule : nrm_io_model

// ===== nrm_pkg.sv
`timescale 1ns/1ps
package nrm_pkg;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ACC = 8'h08;
    localparam logic [7:0] REG_PROD = 8'h0C;
    localparam logic [7:0] REG_INSTR = 8'h10;
    localparam logic [7:0] REG_IPTR = 8'h14;
    localparam logic [7:0] REG_MADDR = 8'h18;
    localparam logic [7:0] REG_MDATA = 8'h1C;
    localparam logic [7:0] REG_AR0 = 8'h20;
    localparam int CTRL_NEWER = 0;
    localparam int CTRL_PM_LO = 1;
    localparam int CTRL_SXM = 3;
    localparam int CTRL_ARP_LO = 4;
    localparam int CTRL_RPT_LO = 8;
    localparam logic [15:0] CTRL_RST = 16'h0001;
    localparam logic [15:0] OP_IDLE = 16'h5500;
    localparam logic [15:0] OP_NORMALIZE_STEP = 16'hCE82;
    localparam logic [15:0] MSK_NORMALIZE_STEP = 16'hFF8F;
    localparam logic [15:0] OP_ORK = 16'hD005;
    localparam logic [15:0] MSK_ORK = 16'hF0FF;
    localparam logic [15:0] OP_PAC = 16'hCE14;
    localparam logic [7:0] OP_OR_HI = 8'h4D;
    localparam logic [3:0] OP_OUT_HI = 4'hE;
    localparam logic [1:0] PM_RSH6 = 2'h3;
    localparam logic [1:0] PM_LSH1 = 2'h1;
    localparam logic [1:0] PM_LSH4 = 2'h2;
    localparam logic [2:0] MOD_DEC = 3'h1;
    localparam logic [2:0] MOD_INC = 3'h2;
    localparam logic [2:0] MOD_SUB0 = 3'h5;
    localparam logic [2:0] MOD_ADD0 = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FETCH = 4'h2,
        ST_EXEC = 4'h4,
        ST_IO = 4'h8
    } nrm_state_e;
endpackage : nrm_pkg

module nrm_dmem #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
    // Registered read, one cycle latency
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule : nrm_dmem

// ===== tb_dsp_normalize_step_logic_io_ops.sv
`timescale 1ns/1ps
module tb_dsp_normalize_step_logic_io_ops;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] dly = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, io_oe, stb_n, dstb_n, wr_n, io_rdy;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, rd;
    logic [31:0] exv;
    logic [15:0] opv;
    logic [15:0] io_addr, io_data, got_addr, got_data;
    logic [7:0] nwr;
    int bad_count = 0;
    int total_checks = 0;
    logic [31:0] oacc[3] = '{32'h2, 32'h0, 32'h80000000};
    logic [15:0] oimm[3] = '{16'hFFFF, 16'hFFFF, 16'h0001};
    logic [3:0] osh[3] = '{4'h8, 4'hF, 4'h0};
    logic [31:0] nacc[4] = '{32'h1000, 32'h40000000, 32'h0, 32'h0};
    logic [31:0] nexp[4] = '{32'h2000, 32'h40000000, 32'h0, 32'h0};
    logic ntc[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] nar[4] = '{32'h6, 32'h5, 32'h5, 32'h6};
    logic [15:0] pop[2] = '{16'hEA22, 16'hE5A0};
    logic [15:0] pdat[2] = '{16'hBEEF, 16'h1357};
    logic [3:0] pdly[2] = '{4'h0, 4'h6};

    initial begin
        forever #2.5 clk = ~clk;
    end

    nrm_core i_nrm_core (.CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .IO_ADDR(io_addr), .IO_DATA_O(io_data), .IO_DATA_OE(io_oe),
        .IO_STROBE_N(stb_n), .IO_DSTRB_N(dstb_n), .IO_WRITE_N(wr_n), .IO_READY(io_rdy));

    nrm_io_model i_nrm_io_model (.CLK(clk), .ARST_N(arst_n), .IO_ADDR(io_addr),
        .IO_DATA_O(io_data), .IO_DATA_OE(io_oe), .IO_STROBE_N(stb_n), .IO_WRITE_N(wr_n),
        .IO_DSTRB_N(dstb_n), .delay(dly), .IO_READY(io_rdy), .got_addr(got_addr),
        .got_data(got_data), .nwr(nwr));

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        if (n >= 50) chk("write timeout", 32'h1, 32'h0);
        if (n >= 50) summarize();
        rs = bresp;
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        if (n >= 50) chk("read timeout", 32'h1, 32'h0);
        if (n >= 50) summarize();
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axr

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axw(a, d, r);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        axr(a, rd, r);
        chk(nm, rd, e);
    endtask : rdc

    task automatic run(input logic [31:0] w);
        int n;
        wr(nrm_pkg::REG_INSTR, w);
        n = 0;
        do begin
            axr(nrm_pkg::REG_STATUS, rd, r);
            n++;
        end while (rd[1] !== 1'b0 && n < 100);
        if (n >= 100) chk("busy timeout", 32'h1, 32'h0);
        if (n >= 100) summarize();
    endtask : run

    function automatic logic [31:0] pexp(input int m);
        logic [31:0] p;
        p = 32'h80001234;
        return m == 0 ? p : m == 1 ? p << 1 : m == 2 ? p << 4 : $unsigned($signed(p) >>> 6);
    endfunction : pexp

    initial begin
        int i;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdc("ctrl reset", nrm_pkg::REG_CTRL, {16'h0, nrm_pkg::CTRL_RST});
        rdc("status reset", nrm_pkg::REG_STATUS, 32'h0);
        axr(8'h40, rd, r);
        chk("unmapped read resp", {30'h0, r}, {30'h0, nrm_pkg::RESP_SLVERR});
        axw(8'h44, 32'h1, r);
        chk("unmapped write resp", {30'h0, r}, {30'h0, nrm_pkg::RESP_SLVERR});
        wr(nrm_pkg::REG_ACC, 32'h12345678);
        run({16'h0, nrm_pkg::OP_IDLE});
        rdc("acc idle", nrm_pkg::REG_ACC, 32'h12345678);
        rdc("iptr idle", nrm_pkg::REG_IPTR, 32'h1);
        for (i = 0; i < 3; i++) begin
            wr(nrm_pkg::REG_ACC, oacc[i]);
            run({oimm[i], nrm_pkg::OP_ORK | {4'h0, osh[i], 8'h00}});
            exv = oacc[i] | ((32'(oimm[i]) << osh[i]) & 32'h7FFFFFFF);
            rdc("acc ork", nrm_pkg::REG_ACC, exv);
        end
        rdc("iptr ork", nrm_pkg::REG_IPTR, 32'h7);
        // Single steps: shift, top bits differ, zero newer, zero older
        for (i = 0; i < 4; i++) begin
            wr(nrm_pkg::REG_CTRL, (i == 3) ? 32'h10 : 32'h11);
            wr(nrm_pkg::REG_ACC, nacc[i]);
            wr(8'(nrm_pkg::REG_AR0 + 8'h04), 32'h5);
            run({16'h0, nrm_pkg::OP_NORMALIZE_STEP | {9'h0, nrm_pkg::MOD_INC, 4'h0}});
            rdc("acc normalize_step", nrm_pkg::REG_ACC, nexp[i]);
            rdc("flag normalize_step", nrm_pkg::REG_STATUS, {31'h0, ntc[i]});
            rdc("aux normalize_step", 8'(nrm_pkg::REG_AR0 + 8'h04), nar[i]);
        end
        // Offset modes step the pointed register by the base register
        wr(nrm_pkg::REG_AR0, 32'h3);
        for (i = 0; i < 2; i++) begin
            wr(nrm_pkg::REG_ACC, 32'h1000);
            opv = {9'h0, (i == 0) ? nrm_pkg::MOD_ADD0 : nrm_pkg::MOD_SUB0, 4'h0};
            run({16'h0, nrm_pkg::OP_NORMALIZE_STEP | opv});
            rdc("aux offset", 8'(nrm_pkg::REG_AR0 + 8'h04), (i == 0) ? 32'h9 : 32'h6);
        end
        // Count of 20 outlasts the 14 shifts needed
        wr(nrm_pkg::REG_CTRL, 32'h1411);
        wr(nrm_pkg::REG_ACC, 32'h00010000);
        wr(8'(nrm_pkg::REG_AR0 + 8'h04), 32'hF);
        run({16'h0, nrm_pkg::OP_NORMALIZE_STEP | {9'h0, nrm_pkg::MOD_DEC, 4'h0}});
        rdc("acc repeat", nrm_pkg::REG_ACC, 32'h40000000);
        rdc("aux repeat", 8'(nrm_pkg::REG_AR0 + 8'h04), 32'h1);
        rdc("flag repeat", nrm_pkg::REG_STATUS, 32'h1);
        wr(nrm_pkg::REG_PROD, 32'h80001234);
        for (i = 0; i < 4; i++) begin
            wr(nrm_pkg::REG_CTRL, (32'(i) << 1) | 32'h1);
            run({16'h0, nrm_pkg::OP_PAC});
            rdc("acc product", nrm_pkg::REG_ACC, pexp(i));
        end
        wr(nrm_pkg::REG_CTRL, 32'h9);
        wr(nrm_pkg::REG_MADDR, 32'h10);
        wr(nrm_pkg::REG_MDATA, 32'hF000);
        wr(nrm_pkg::REG_ACC, 32'hABCD0002);
        run({16'h0, nrm_pkg::OP_OR_HI, 8'h10});
        rdc("acc or mem", nrm_pkg::REG_ACC, 32'hABCDF002);
        // Direct to port A with prompt answer, indirect to port 5 with slow answer
        wr(nrm_pkg::REG_CTRL, 32'h11);
        wr(8'(nrm_pkg::REG_AR0 + 8'h04), 32'h23);
        for (i = 0; i < 2; i++) begin
            wr(nrm_pkg::REG_MADDR, 32'h22 + 32'(i));
            wr(nrm_pkg::REG_MDATA, {16'h0, pdat[i]});
        end
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            dly <= pdly[i];
            run({16'h0, pop[i]});
            chk("port addr", {16'h0, got_addr}, {28'h0, pop[i][11:8]});
            chk("port data", {16'h0, got_data}, {16'h0, pdat[i]});
            chk("port count", {24'h0, nwr}, 32'(i + 1));
            chk("strobe released", {31'h0, stb_n}, 32'h1);
        end
        rdc("aux port", 8'(nrm_pkg::REG_AR0 + 8'h04), 32'h24);
        summarize();
    end
endmodule : tb_dsp_normalize_step_logic_io_ops
